// ---- rtl/pwr_mgr_defines.svh ----
// offsets, field positions, reset values and timing counts of the power manager
`ifndef PWR_MGR_DEFINES_SVH
`define PWR_MGR_DEFINES_SVH
`define OFS_PWR_CTRL    8'h00
`define OFS_SLEEP_DLY   8'h04
`define OFS_PORT_PD     8'h08
`define OFS_PHY_PD      8'h0c
`define OFS_EEE_CTRL    8'h10
`define OFS_STATUS      8'h14
`define MODE_LSB        3
`define MODE_MSB        4
`define RST_SLEEP_DLY   8'h00
`define RST_EEE_CTRL    3'h0
`define EEE_REQ_BIT     0
`define EEE_ADV_BIT     1
`define LPI_TXD         4'h1
`define CLK_MHZ         250
`define PULSE_NS        120
`define PULSE_CYC       ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define PERIOD_CYC      250000000
`define TICK_CYC        250000
`define WAKE_CYC        64
`endif

// ---- rtl/pwr_mgr_pkg.sv ----
// types shared by the power manager
package pwr_mgr_pkg;
    typedef enum logic [1:0] {
        mode_normal = 2'b00,
        mode_energy = 2'b01,
        mode_soft   = 2'b10,
        mode_resvd  = 2'b11
    } pwr_mode_t;
    typedef enum logic [1:0] {
        st_normal   = 2'b00,
        st_ed_awake = 2'b01,
        st_ed_sleep = 2'b10,
        st_soft_pd  = 2'b11
    } pwr_state_t;
    typedef enum logic [1:0] {
        tx_run  = 2'b00,
        tx_lpi  = 2'b01,
        tx_wake = 2'b10
    } lpi_tx_t;
endpackage

// ---- rtl/switch_power_mode_manager.sv ----
// power mode sequencer, energy detect and low-power-idle control of the switch
`timescale 1ns/1ps
`include "pwr_mgr_defines.svh"
module switch_power_mode_manager #(
    parameter int NPORT      = 5,
    parameter int PERIOD_CYC = `PERIOD_CYC,
    parameter int TICK_CYC   = `TICK_CYC,
    parameter int WAKE_CYC   = `WAKE_CYC
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // avalon-mm register slave
    input  wire logic [7:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    // power and clock gating
    output logic                        pll_clk_en,
    output logic                        mac_pwr_en,
    output logic                        host_if_en,
    output logic                        rx_energy_det_en,
    output logic      [NPORT-1:0]       phy_pwr_en,
    output logic                        internal_rst_n,
    output pwr_mgr_pkg::pwr_state_t     pwr_state,
    // cable side
    input  wire logic                   cable_energy,
    output logic                        line_pulse,
    // negotiation result
    input  wire logic                   partner_eee_adv,
    // mac transmit side
    input  wire logic                   mac_tx_en,
    input  wire logic                   mac_tx_er,
    input  wire logic [3:0]             mac_txd,
    output logic                        mac_crs,
    output logic                        mac_tx_allow,
    output logic                        mac_tx_clk_en,
    output logic                        mac_rx_clk_en,
    // mii transmit to phy
    output logic                        mii_tx_en,
    output logic                        mii_tx_er,
    output logic      [3:0]             mii_txd,
    // mii receive from phy
    input  wire logic                   mii_rx_dv,
    input  wire logic                   mii_rx_er,
    input  wire logic [3:0]             mii_rxd,
    // mac receive side
    output logic                        mac_rx_dv,
    output logic                        mac_rx_er,
    output logic      [3:0]             mac_rxd,
    output logic                        partner_idle_flag
);
    import pwr_mgr_pkg::*;
    localparam int PULSE_CYC = `PULSE_CYC;

    logic [1:0]        mode;
    logic [7:0]        sleep_dly;
    logic [NPORT-1:0]  port_pd;
    logic [NPORT-1:0]  phy_pd;
    logic [2:0]        eee_ctrl;
    logic              req;
    logic              acc;
    logic              wake_rst;
    logic              eee_ok;
    logic              full_pwr;
    logic [27:0]       sec_cnt;
    logic [17:0]       tick_cnt;
    logic              tick;
    logic [7:0]        idle_cnt;
    lpi_tx_t           tx_st;
    logic [15:0]       wake_cnt;
    logic              rx_lpi;
    logic [31:0]       next_rdata;
    pwr_state_t        next_state;

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the access completes
    assign req = read | write;
    assign acc = req & ~waitrequest;
    // any access while powered down wakes the part
    assign wake_rst = acc & (pwr_state == st_soft_pd);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(req & waitrequest);
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        unique case (address)
            `OFS_PWR_CTRL:  next_rdata[`MODE_MSB:`MODE_LSB] = mode;
            `OFS_SLEEP_DLY: next_rdata[7:0] = sleep_dly;
            `OFS_PORT_PD:   next_rdata[NPORT-1:0] = port_pd;
            `OFS_PHY_PD:    next_rdata[NPORT-1:0] = phy_pd;
            `OFS_EEE_CTRL:  next_rdata[2:0] = eee_ctrl;
            `OFS_STATUS: begin
                next_rdata[1:0] = pwr_state;
                next_rdata[3:2] = tx_st;
                next_rdata[4]   = partner_idle_flag;
                next_rdata[5]   = eee_ok;
            end
            default:        next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            readdata <= 32'h0;
        end else if (read & waitrequest) begin
            readdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers; a wake access restores every default
    always_ff @(posedge core_clk) begin
        if (!rstn || wake_rst) begin
            mode      <= mode_normal;
            sleep_dly <= `RST_SLEEP_DLY;
            port_pd   <= '0;
            phy_pd    <= '0;
            eee_ctrl  <= `RST_EEE_CTRL;
        end else if (acc && write) begin
            unique case (address)
                `OFS_PWR_CTRL:  mode <= writedata[`MODE_MSB:`MODE_LSB];
                `OFS_SLEEP_DLY: sleep_dly <= writedata[7:0];
                `OFS_PORT_PD:   port_pd <= writedata[NPORT-1:0];
                `OFS_PHY_PD:    phy_pd <= writedata[NPORT-1:0];
                `OFS_EEE_CTRL:  eee_ctrl <= writedata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            internal_rst_n <= 1'b1;
        end else begin
            internal_rst_n <= ~wake_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sleep delay timebase: one tick per TICK_CYC cycles
    always_ff @(posedge core_clk) begin
        if (!rstn || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 18'h1;
        end
    end
    assign tick = (tick_cnt == 18'(TICK_CYC - 1));
    always_ff @(posedge core_clk) begin
        if (!rstn || cable_energy || pwr_state != st_ed_awake) begin
            idle_cnt <= '0;
        end else if (tick && idle_cnt != 8'hff) begin
            idle_cnt <= idle_cnt + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power state sequencer
    always_comb begin
        next_state = pwr_state;
        unique case (pwr_state)
            st_normal, st_ed_awake, st_ed_sleep: begin
                unique case (mode)
                    mode_energy: begin
                        if (pwr_state == st_normal) begin
                            next_state = st_ed_awake;
                        end else if (pwr_state == st_ed_sleep) begin
                            if (cable_energy) begin
                                next_state = st_ed_awake;
                            end
                        end else if (!cable_energy && idle_cnt > sleep_dly) begin
                            next_state = st_ed_sleep;
                        end
                    end
                    mode_soft:   next_state = st_soft_pd;
                    // reserved code holds normal operation
                    mode_normal, mode_resvd: next_state = st_normal;
                endcase
            end
            st_soft_pd: begin
                if (wake_rst) begin
                    next_state = st_normal;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pwr_state <= st_normal;
        end else begin
            pwr_state <= next_state;
        end
    end

    // awake half of energy mode runs like normal so packets flow
    assign full_pwr = (next_state == st_normal) || (next_state == st_ed_awake);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pll_clk_en       <= 1'b1;
            mac_pwr_en       <= 1'b1;
            host_if_en       <= 1'b1;
            rx_energy_det_en <= 1'b0;
        end else begin
            pll_clk_en       <= full_pwr;
            mac_pwr_en       <= full_pwr;
            host_if_en       <= full_pwr;
            rx_energy_det_en <= (next_state == st_ed_sleep);
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    phy_pwr_en[gp] <= 1'b1;
                end else begin
                    phy_pwr_en[gp] <= full_pwr & ~port_pd[gp] & ~phy_pd[gp];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // link pulse once per second, restarted on entry so the first pulse is full width; leaving energy mode ends a pulse at once
    always_ff @(posedge core_clk) begin
        if (!rstn || sec_cnt == 28'(PERIOD_CYC - 1) || !(pwr_state == st_ed_awake || pwr_state == st_ed_sleep)) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_cnt + 28'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            line_pulse <= 1'b0;
        end else begin
            line_pulse <= (pwr_state == st_ed_awake || pwr_state == st_ed_sleep)
                          && sec_cnt < 28'(PULSE_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // low-power idle, transmit direction
    assign eee_ok = eee_ctrl[`EEE_ADV_BIT] & partner_eee_adv;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_st    <= tx_run;
            wake_cnt <= '0;
        end else begin
            unique case (tx_st)
                tx_run: begin
                    // enter only between frames so nothing is cut
                    if (eee_ctrl[`EEE_REQ_BIT] && eee_ok && !mac_tx_en
                        && pwr_state == st_normal) begin
                        tx_st <= tx_lpi;
                    end
                end
                tx_lpi: begin
                    if (!eee_ctrl[`EEE_REQ_BIT] || !eee_ok) begin
                        tx_st    <= tx_wake;
                        wake_cnt <= '0;
                    end
                end
                tx_wake: begin
                    // partner needs time before traffic resumes
                    if (wake_cnt == 16'(WAKE_CYC - 1)) begin
                        tx_st <= tx_run;
                    end else begin
                        wake_cnt <= wake_cnt + 16'h1;
                    end
                end
                default: tx_st <= tx_run;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mii_tx_en <= 1'b0;
            mii_tx_er <= 1'b0;
            mii_txd   <= 4'h0;
        end else if (tx_st == tx_lpi) begin
            mii_tx_en <= 1'b0;
            mii_tx_er <= 1'b1;
            mii_txd   <= `LPI_TXD;
        end else if (tx_st == tx_wake) begin
            mii_tx_en <= 1'b0;
            mii_tx_er <= 1'b0;
            mii_txd   <= 4'h0;
        end else begin
            mii_tx_en <= mac_tx_en;
            mii_tx_er <= mac_tx_er;
            mii_txd   <= mac_txd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mac_crs       <= 1'b0;
            mac_tx_allow  <= 1'b1;
            mac_tx_clk_en <= 1'b1;
        end else begin
            mac_crs       <= (tx_st != tx_run);
            mac_tx_allow  <= (tx_st == tx_run);
            mac_tx_clk_en <= (tx_st != tx_lpi) && full_pwr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // low-power idle, receive direction
    assign rx_lpi = eee_ok && !mii_rx_dv && mii_rx_er && mii_rxd == `LPI_TXD;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            partner_idle_flag <= 1'b0;
            mac_rx_dv         <= 1'b0;
            mac_rx_er         <= 1'b0;
            mac_rxd           <= 4'h0;
            mac_rx_clk_en     <= 1'b1;
        end else begin
            partner_idle_flag <= rx_lpi;
            mac_rx_clk_en     <= ~rx_lpi && full_pwr;
            if (rx_lpi) begin
                mac_rx_dv <= 1'b0;
                mac_rx_er <= 1'b0;
                mac_rxd   <= 4'h0;
            end else begin
                mac_rx_dv <= mii_rx_dv;
                mac_rx_er <= mii_rx_er;
                mac_rxd   <= mii_rxd;
            end
        end
    end
endmodule

// ---- test/pwr_mgr_checker_asserts.sv ----
// port-level assertion checker for the power mode manager
`timescale 1ns/1ps
`include "pwr_mgr_defines.svh"
module pwr_mgr_checker
    import pwr_mgr_pkg::*;
(
    // clock, reset and bus handshake
    input wire logic             core_clk,
    input wire logic             rstn,
    input wire logic             read,
    input wire logic             write,
    input wire logic             waitrequest,
    // power control
    input wire logic             pll_clk_en,
    input wire logic             mac_pwr_en,
    input wire logic             host_if_en,
    input wire logic             rx_energy_det_en,
    input wire logic             internal_rst_n,
    input pwr_mgr_pkg::pwr_state_t pwr_state,
    input wire logic             cable_energy,
    input wire logic             line_pulse,
    input wire logic             partner_eee_adv,
    // low-power idle
    input wire logic             mac_crs,
    input wire logic             mac_tx_allow,
    input wire logic             mii_tx_en,
    input wire logic             mii_tx_er,
    input wire logic [3:0]       mii_txd,
    input wire logic             mii_rx_dv,
    input wire logic             mii_rx_er,
    input wire logic [3:0]       mii_rxd,
    input wire logic             mac_rx_dv,
    input wire logic             partner_idle_flag
);
    logic [7:0] hi_cnt;
    logic       tx_idle;
    logic       rx_idle;
    assign tx_idle = mii_tx_er && !mii_tx_en && mii_txd == `LPI_TXD;
    assign rx_idle = mii_rx_er && !mii_rx_dv && mii_rxd == 4'h1;
    // counts the width of the line pulse, far beyond what a repetition may unroll
    always_ff @(posedge core_clk) begin
        if (!rstn || !line_pulse)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= hi_cnt + 8'h01;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait state");
    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    normal_on_a: assert property (pwr_state == st_normal && $past(pwr_state) == st_normal
        |-> pll_clk_en && mac_pwr_en && host_if_en && !rx_energy_det_en)
        else $error("normal mode not fully powered");
    sleep_gate_a: assert property (pwr_state == st_ed_sleep && $past(pwr_state) == st_ed_sleep
        |-> rx_energy_det_en && !pll_clk_en && !mac_pwr_en && !host_if_en)
        else $error("sleep state gating wrong");
    soft_off_a: assert property (pwr_state == st_soft_pd && $past(pwr_state) == st_soft_pd
        |-> !pll_clk_en && !mac_pwr_en) else $error("soft power-down left clocks on");
    energy_wake_a: assert property (pwr_state == st_ed_sleep && cable_energy
        |-> ##[1:3] pwr_state == st_ed_awake) else $error("no wake on cable energy");
    soft_wake_a: assert property (pwr_state == st_soft_pd && (read || write) && !waitrequest
        |-> ##[1:3] pwr_state == st_normal) else $error("host access did not wake device");
    rst_pulse_a: assert property (!internal_rst_n |=> internal_rst_n)
        else $error("internal reset longer than one cycle");
    pulse_width_a: assert property ($fell(line_pulse) |-> hi_cnt == `PULSE_CYC)
        else $error("line pulse width wrong");
    tx_idle_crs_a: assert property (tx_idle && $past(tx_idle)
        |-> mac_crs && !mac_tx_allow && $past(partner_eee_adv)) else $error("idle without deferral");
    rx_flag_a: assert property (partner_idle_flag
        |-> $past(rx_idle) && $past(partner_eee_adv) && !mac_rx_dv) else $error("partner flag wrong");
    sleep_c: cover property (pwr_state == st_ed_sleep);
    tx_idle_c: cover property (tx_idle);
    flag_c: cover property (partner_idle_flag);
    wake_c: cover property (!internal_rst_n);
endmodule
bind switch_power_mode_manager pwr_mgr_checker chk_u (.core_clk(core_clk), .rstn(rstn), .read(read),
    .write(write), .waitrequest(waitrequest), .pll_clk_en(pll_clk_en), .mac_pwr_en(mac_pwr_en),
    .host_if_en(host_if_en), .rx_energy_det_en(rx_energy_det_en), .internal_rst_n(internal_rst_n),
    .pwr_state(pwr_state), .cable_energy(cable_energy), .line_pulse(line_pulse),
    .partner_eee_adv(partner_eee_adv), .mac_crs(mac_crs), .mac_tx_allow(mac_tx_allow),
    .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_txd(mii_txd), .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd), .mac_rx_dv(mac_rx_dv), .partner_idle_flag(partner_idle_flag));

// ---- test/phy_link_model.sv ----
// far-side phy model: receive mii stream and cable energy
`timescale 1ns/1ps
module phy_link_model (
    // control from the bench
    input  wire logic  core_clk,
    input  wire logic  lpi_on,
    input  wire logic  energy_on,
    // mii receive and line
    output logic       mii_rx_dv,
    output logic       mii_rx_er,
    output logic [3:0] mii_rxd,
    output logic       cable_energy
);
    logic [3:0] pat;
    initial begin
        pat = 4'h0;
        {mii_rx_dv, mii_rx_er, mii_rxd, cable_energy} = 7'h00;
    end
    // data nibble changes every cycle so a stale copy never passes for a match
    always @(posedge core_clk) begin
        pat <= pat + 4'h3;
        cable_energy <= energy_on;
        mii_rx_dv <= !lpi_on;
        mii_rx_er <= lpi_on;
        mii_rxd <= lpi_on ? 4'h1 : pat;
    end
endmodule

// ---- test/switch_power_mode_manager_tb.sv ----
// self-checking bench for the power mode manager
`timescale 1ns/1ps
`include "pwr_mgr_defines.svh"
module switch_power_mode_manager_tb;
    import pwr_mgr_pkg::*;
    localparam int TICK = 4;
    localparam int WAKE = 4;
    logic core_clk, rstn, read, write, waitrequest, cable_energy, line_pulse, partner_eee_adv;
    logic pll_clk_en, mac_pwr_en, host_if_en, rx_energy_det_en, internal_rst_n, lpi_on, energy_on;
    logic mac_tx_en, mac_tx_er, mac_crs, mac_tx_allow, mac_tx_clk_en, mii_tx_en, mii_tx_er;
    logic mii_rx_dv, mii_rx_er, mac_rx_dv, mac_rx_er, partner_idle_flag, mac_rx_clk_en;
    logic [3:0] mac_txd, mii_txd, mii_rxd, mac_rxd, v;
    logic [4:0] phy_pwr_en;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q;
    pwr_state_t pwr_state;
    int mismatches, n_tests, n, i;
    bit seen;
    ////////////////////////////////////////////////////////////////////////////////
    switch_power_mode_manager #(.PERIOD_CYC(200), .TICK_CYC(TICK), .WAKE_CYC(WAKE)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pll_clk_en(pll_clk_en),
        .mac_pwr_en(mac_pwr_en), .host_if_en(host_if_en), .rx_energy_det_en(rx_energy_det_en),
        .phy_pwr_en(phy_pwr_en), .internal_rst_n(internal_rst_n), .pwr_state(pwr_state),
        .cable_energy(cable_energy), .line_pulse(line_pulse), .partner_eee_adv(partner_eee_adv),
        .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er), .mac_txd(mac_txd), .mac_crs(mac_crs),
        .mac_tx_allow(mac_tx_allow), .mac_tx_clk_en(mac_tx_clk_en), .mac_rx_clk_en(mac_rx_clk_en),
        .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_txd(mii_txd), .mii_rx_dv(mii_rx_dv),
        .mii_rx_er(mii_rx_er),
        .mii_rxd(mii_rxd), .mac_rx_dv(mac_rx_dv), .mac_rx_er(mac_rx_er), .mac_rxd(mac_rxd),
        .partner_idle_flag(partner_idle_flag));
    phy_link_model pm_u (.core_clk(core_clk), .lpi_on(lpi_on), .energy_on(energy_on), .mii_rx_dv(mii_rx_dv),
        .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd), .cable_energy(cable_energy));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge core_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) begin
            chk("waitrequest", 32'h0, 32'h1);
            stop_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic wait_st(input pwr_state_t s, input int lim);
        n = 0;
        while (pwr_state !== s && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk("pwr_state", {30'h0, s}, {30'h0, pwr_state});
        if (pwr_state !== s) stop_test();
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, read, write, partner_eee_adv, mac_tx_en, mac_tx_er, lpi_on} = 7'h00;
        {address, writedata, mac_txd} = 44'h0;
        energy_on = 1'b1;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`OFS_PWR_CTRL, 32'h0, "pwr_ctrl_reset");
        chk("enables", 32'h7, {29'h0, pll_clk_en, mac_pwr_en, host_if_en});
        rd(8'h1c, 32'h0, "unmapped");
        bus(1'b1, `OFS_PWR_CTRL, 32'h18);
        repeat (3) @(posedge core_clk);
        chk("resvd_state", 32'h0, {30'h0, pwr_state});
        rd(`OFS_PWR_CTRL, 32'h18, "pwr_ctrl_resvd");
        bus(1'b1, `OFS_PWR_CTRL, 32'h0);
        bus(1'b1, `OFS_PORT_PD, 32'h01);
        bus(1'b1, `OFS_PHY_PD, 32'h04);
        repeat (2) @(posedge core_clk);
        chk("phy_pwr_en", 32'h1a, {27'h0, phy_pwr_en});
        bus(1'b1, `OFS_PORT_PD, 32'h0);
        bus(1'b1, `OFS_PHY_PD, 32'h0);
        $display("test reset_and_ports done");
        partner_eee_adv <= 1'b1;
        bus(1'b1, `OFS_EEE_CTRL, 32'h3);
        repeat (4) @(posedge core_clk);
        chk("tx_idle_code", 32'h11, {26'h0, mii_tx_en, mii_tx_er, mii_txd});
        chk("crs_allow", 32'h2, {30'h0, mac_crs, mac_tx_allow});
        chk("tx_clk_gate", 32'h0, {31'h0, mac_tx_clk_en});
        rd(`OFS_STATUS, 32'h24, "status_lpi");
        v = mii_rxd;
        @(posedge core_clk);
        chk("rx_passes", {28'h0, v}, {28'h0, mac_rxd});
        bus(1'b1, `OFS_EEE_CTRL, 32'h2);
        repeat (3) @(posedge core_clk);
        chk("tx_wake_code", 32'h0, {26'h0, mii_tx_en, mii_tx_er, mii_txd});
        chk("allow_held", 32'h0, {31'h0, mac_tx_allow});
        repeat (WAKE + 3) @(posedge core_clk);
        chk("allow_back", 32'h1, {31'h0, mac_tx_allow});
        lpi_on <= 1'b1;
        mac_tx_en <= 1'b1;
        mac_txd <= 4'h5;
        repeat (3) @(posedge core_clk);
        chk("flag_dv", 32'h8, {28'h0, partner_idle_flag, mac_rx_dv, mac_rx_er, mac_rx_clk_en});
        chk("tx_runs", 32'h25, {26'h0, mii_tx_en, mii_tx_er, mii_txd});
        lpi_on <= 1'b0;
        mac_tx_en <= 1'b0;
        mac_txd <= 4'h0;
        repeat (3) @(posedge core_clk);
        chk("flag_clear", 32'h1, {30'h0, partner_idle_flag, mac_rx_clk_en});
        partner_eee_adv <= 1'b0;
        bus(1'b1, `OFS_EEE_CTRL, 32'h3);
        lpi_on <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("no_adv", 32'h0, {25'h0, partner_idle_flag, mii_tx_en, mii_tx_er, mii_txd});
        lpi_on <= 1'b0;
        bus(1'b1, `OFS_EEE_CTRL, 32'h0);
        $display("test low_power_idle done");
        bus(1'b1, `OFS_SLEEP_DLY, 32'h2);
        energy_on <= 1'b0;
        bus(1'b1, `OFS_PWR_CTRL, 32'h08);
        wait_st(st_ed_awake, 10);
        wait_st(st_ed_sleep, 100);
        chk("sleep_late", 32'h1, {31'h0, n >= 2 * TICK});
        @(posedge core_clk);
        chk("sleep_gates", 32'h1, {28'h0, pll_clk_en, mac_pwr_en, host_if_en, rx_energy_det_en});
        seen = 1'b0;
        for (i = 0; i < 250; i++) begin
            @(posedge core_clk);
            if (line_pulse === 1'b1) seen = 1'b1;
        end
        chk("line_pulse", 32'h1, {31'h0, seen});
        energy_on <= 1'b1;
        wait_st(st_ed_awake, 10);
        bus(1'b1, `OFS_PWR_CTRL, 32'h0);
        wait_st(st_normal, 10);
        $display("test energy_detect done");
        bus(1'b1, `OFS_PWR_CTRL, 32'h10);
        wait_st(st_soft_pd, 10);
        @(posedge core_clk);
        chk("soft_off", 32'h0, {25'h0, pll_clk_en, mac_pwr_en, phy_pwr_en});
        bus(1'b1, `OFS_SLEEP_DLY, 32'h5);
        wait_st(st_normal, 10);
        rd(`OFS_SLEEP_DLY, 32'h0, "sleep_dly_default");
        rd(`OFS_PWR_CTRL, 32'h0, "pwr_ctrl_default");
        $display("test soft_power_down done");
        stop_test();
    end
endmodule
